/* verification/ump_phy_model.sv */
// PHY-side model: one cell-available flag per enable/clav pair.
// Assumes the bench sets the ready flags and the pair count.
`timescale 1ns/1ps

module ump_phy_model (
  input wire logic [3:0] ready, // Cells waiting per pair
  input wire logic [2:0] pairs, // Pairs wired in this mode
  output logic [3:0] phy_clav // Cell-available lines
);
  // Unwired clav lines are grounded, never left floating
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      phy_clav[i] = ready[i] && (i < pairs);
    end
  end
endmodule // ump_phy_model

/* verification/ump_port_map_test.sv */
// Self-checking bench for the port map against an integer model.
// Assumes one wait state per bus access and one-cycle select latency.
`timescale 1ns/1ps

module ump_port_map_test;
  import ump_pkg::*;
  logic clk_sys, arst_n, avs_read, avs_write, sel_valid;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic avs_waitrequest, sel_mapped, sel_clav, queue_prog, cfg_error;
  logic [4:0] sel_port, phy_addr;
  logic [3:0] phy_clav, phy_enb_n, ready, pc;
  logic [2:0] queues_per_phy, npairs;
  int num_errors, tests_run, al[8], pr[8], nq, g, ix, mp, ce;

  ump_port_map i_ump_port_map (.clk_sys(clk_sys), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sel_valid(sel_valid), .sel_port(sel_port), .phy_clav(phy_clav),
    .phy_enb_n(phy_enb_n), .phy_addr(phy_addr), .sel_mapped(sel_mapped),
    .sel_clav(sel_clav), .queues_per_phy(queues_per_phy),
    .queue_prog(queue_prog), .cfg_error(cfg_error));
  ump_phy_model i_ump_phy_model (.ready(ready), .pairs(npairs),
    .phy_clav(phy_clav));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic tally_and_finish();
    $display("errors %0d, comparisons %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    // Start on an edge: strobes never retoggle in one time step
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      tally_and_finish();
    end
  endtask

  task automatic run_mode(input int m, input int qs, input int nm);
    bus(1'b1, 12'h448, {28'h0, qs[0], m[2:0]});
    bus(1'b1, 12'h450, {31'h0, nm[0]});
    npairs <= pr[m][2:0];
    @(posedge clk_sys);
    #1;
    if (m == 3) nq = nm ? 2 : 0;
    else if (m[0]) nq = qs ? 4 : (nm ? 2 : 0);
    else nq = 4;
    ce = (m == 3 && qs == 0);
    chk(queues_per_phy, nq);
    chk(queue_prog, nq == 0);
    chk(cfg_error, ce);
    bus(1'b0, 12'h454, 32'h0000_0000);
    chk({rd[12], rd[10:8], rd[6:4], rd[2:0]},
        {ce[0], nq[2:0], pr[m][2:0], al[m][2:0]});
    g = al[m] + (m % 2 == 0);
    for (int p = 0; p <= 32; p++) begin
      @(posedge clk_sys);
      sel_valid <= p < 32;
      sel_port <= p[4:0];
      ready <= 4'($urandom);
      #1;
      if (p > 0) begin
        ix = (p - 1) >> g;
        mp = (p - 1) < (pr[m] << g) && !(m % 2 == 0 && p % 2 == 0) && !ce;
        chk(sel_mapped, mp);
        chk(phy_enb_n, mp ? 4'(~(4'h1 << ix)) : 4'hF);
        chk(sel_clav, mp ? pc[ix] : 1'b0);
        if (mp) chk(phy_addr, (p - 1) & ((1 << g) - 1));
      end
      pc = phy_clav;
    end
    // Select dropped: status keeps last address, mapped flag clear
    bus(1'b0, 12'h454, 32'h0000_0000);
    chk({rd[20:16], rd[13]}, {5'(31 & ((1 << g) - 1)), 1'b0});
  endtask

  initial begin
    al = '{0, 4, 1, 4, 2, 2, 3, 3};
    pr = '{4, 1, 4, 2, 2, 4, 1, 2};
    num_errors = 0;
    tests_run = 0;
    arst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 12'h000;
    avs_writedata = 32'h0000_0000;
    sel_valid = 1'b0;
    sel_port = 5'h00;
    ready = 4'h0;
    npairs = 3'h4;
    void'($urandom(80196));
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk(queues_per_phy, 4);
    chk(phy_enb_n, 4'hF);
    bus(1'b0, 12'h448, 32'h0000_0000);
    chk(rd, 0);
    bus(1'b0, 12'h450, 32'h0000_0000);
    chk(rd, 1);
    bus(1'b1, 12'h000, 32'hFFFF_FFFF);
    bus(1'b0, 12'h000, 32'h0000_0000);
    chk(rd, 0);
    for (int m = 0; m < 8; m++)
      for (int k = 0; k < 4; k++) run_mode(m, k / 2, k % 2);
    @(posedge clk_sys);
    arst_n <= 1'b0;
    @(posedge clk_sys);
    arst_n <= 1'b1;
    bus(1'b0, 12'h448, 32'h0000_0000);
    chk(rd, 0);
    run_mode(1, 1, $urandom % 2);
    tally_and_finish();
  end
endmodule // ump_port_map_test

/* verilog/ump_params.svh */
// Constants for the multi-PHY UTOPIA port map block.
// Assumes inclusion by ump_pkg and ump_port_map; definitions only.
//
// Overview of operation
// - Mode 001 gives four address lines, one pair
// - Mode 001 with depth select: four queues
// - Mode 001 without select: two or programmable
// - Mode 011 gives four address lines, two pairs
// - Mode 011: two queues or programmable sizing
// - Port maps to group index and offset
// - Mode field sits in configuration bits 2:0
`ifndef UMP_PARAMS_SVH
`define UMP_PARAMS_SVH

// Register indices; byte address is four times the index
`define UMP_IDX_CFG2 10'h112
`define UMP_IDX_QCTL 10'h114
`define UMP_IDX_STAT 10'h115

// Second main configuration register fields
`define UMP_MODE_MSB 2
`define UMP_QSEL_BIT 3
// Queue control register field
`define UMP_NORM_BIT 0
// Status register fields
`define UMP_ST_ALINES 2:0
`define UMP_ST_PAIRS 6:4
`define UMP_ST_QUEUES 10:8
`define UMP_ST_ERR 12
`define UMP_ST_MAPPED 13
`define UMP_ST_ADDR 20:16

`define UMP_CFG2_RST 3'h0
`define UMP_NORM_RST 1'b1
`define UMP_ADDR_RST 5'h00
`define UMP_WORD_ZERO 32'h0000_0000
`define UMP_ENB_IDLE 4'hF

// Address-line / pair selections
`define UMP_M_0A4P 3'b000
`define UMP_M_1A4P 3'b010
`define UMP_M_2A4P 3'b101
`define UMP_M_2A2P 3'b100
`define UMP_M_3A2P 3'b111
`define UMP_M_3A1P 3'b110
`define UMP_M_4A1P 3'b001
`define UMP_M_4A2P 3'b011

// Queues per PHY encodings; zero means taken from queue registers
`define UMP_Q_FOUR 3'h4
`define UMP_Q_TWO 3'h2
`define UMP_Q_PROG 3'h0

`endif

/* verilog/ump_pkg.sv */
// Types for the multi-PHY UTOPIA port map block.
// Assumes ump_params.svh is on the include path.
`include "ump_params.svh"

package ump_pkg;
  typedef logic [2:0] ump_mode_t;
  typedef enum logic [1:0] {QM_FOUR, QM_TWO, QM_PROG} ump_qmode_t;
endpackage

/* verilog/ump_port_decode.sv */
// Combinational decode of one port number under a pin mode.
// Assumes a stable mode from the configuration register.
`timescale 1ns/1ps
`include "ump_params.svh"

module ump_port_decode
  import ump_pkg::*;
(
  input wire ump_mode_t mode, // Pin mode selection
  input wire logic [4:0] port, // Internal port number
  output logic [1:0] idx, // Enable / cell-available index
  output logic [4:0] addr, // Address within the group
  output logic [2:0] alines, // Address lines in use
  output logic [2:0] pairs, // Enable / cell-available pairs
  output logic mapped // Port exists in this mode
);
  logic sparse;
  logic [2:0] shift;
  logic [4:0] grp;
  logic [5:0] mask;

  always_comb begin
    alines = 3'd0;
    pairs = 3'd4;
    sparse = 1'b0;
    case (mode)
      `UMP_M_0A4P: begin alines = 3'd0; pairs = 3'd4; sparse = 1'b1; end
      `UMP_M_1A4P: begin alines = 3'd1; pairs = 3'd4; sparse = 1'b1; end
      `UMP_M_2A4P: begin alines = 3'd2; pairs = 3'd4; end
      `UMP_M_2A2P: begin alines = 3'd2; pairs = 3'd2; sparse = 1'b1; end
      `UMP_M_3A2P: begin alines = 3'd3; pairs = 3'd2; end
      `UMP_M_3A1P: begin alines = 3'd3; pairs = 3'd1; sparse = 1'b1; end
      `UMP_M_4A1P: begin alines = 3'd4; pairs = 3'd1; end
      default: begin alines = 3'd4; pairs = 3'd2; end
    endcase
    // Sparse modes step by two, so each group spans twice the ports
    shift = alines + {2'b00, sparse};
    grp = port >> shift;
    mask = (6'd1 << shift) - 6'd1;
    addr = port & mask[4:0];
    idx = grp[1:0];
    mapped = ({1'b0, grp} < {3'b000, pairs}) &&
             !(sparse && port[0]);
  end
endmodule // ump_port_decode

/* verilog/ump_port_map.sv */
// Multi-PHY port map: Avalon-MM configuration, port select to pins.
// Assumes a synchronous PHY side on clk_sys; one bus wait cycle.
`timescale 1ns/1ps
`include "ump_params.svh"

module ump_port_map
  import ump_pkg::*;
(
  input wire logic clk_sys, // 40 MHz system clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic [11:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall while high
  input wire logic sel_valid, // Port select request
  input wire logic [4:0] sel_port, // Port number 0 to 31
  input wire logic [3:0] phy_clav, // Cell-available inputs
  output logic [3:0] phy_enb_n, // Enables, active low
  output logic [4:0] phy_addr, // PHY address
  output logic sel_mapped, // Select in the previous cycle was a real port
  output logic sel_clav, // Cell available of that port
  output logic [2:0] queues_per_phy, // 4, 2, or 0 when programmable
  output logic queue_prog, // Sizes come from queue registers
  output logic cfg_error // Mode 011 without depth select
);
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  ump_mode_t mode_q, mode_d;
  logic qsel_q, qsel_d;
  logic norm_q, norm_d;
  logic [3:0] enb_q, enb_d;
  logic [4:0] addr_q, addr_d;
  logic mapped_q, mapped_d;
  logic clav_q, clav_d;
  ump_qmode_t qm_q, qm_d;
  logic err_q, err_d;
  logic [1:0] dec_idx;
  logic [4:0] dec_addr;
  logic [2:0] dec_alines;
  logic [2:0] dec_pairs;
  logic dec_mapped;
  logic map_ok;
  logic [9:0] widx;

  ump_port_decode u_dec (
    .mode(mode_q),
    .port(sel_port),
    .idx(dec_idx),
    .addr(dec_addr),
    .alines(dec_alines),
    .pairs(dec_pairs),
    .mapped(dec_mapped)
  );

  assign widx = avs_address[11:2];
  // Bad 32-port setup must not drive a PHY half of which is missing
  assign map_ok = dec_mapped && !err_q;
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign avs_readdata = rdata_q;

  // Bus slave and configuration registers
  always_comb begin
    ack_d = (avs_read || avs_write) && !ack_q;
    rdata_d = rdata_q;
    mode_d = mode_q;
    qsel_d = qsel_q;
    norm_d = norm_q;
    if (ack_d && avs_read) begin
      rdata_d = `UMP_WORD_ZERO;
      if (widx == `UMP_IDX_CFG2) begin
        rdata_d[`UMP_MODE_MSB:0] = mode_q;
        rdata_d[`UMP_QSEL_BIT] = qsel_q;
      end else if (widx == `UMP_IDX_QCTL) begin
        rdata_d[`UMP_NORM_BIT] = norm_q;
      end else if (widx == `UMP_IDX_STAT) begin
        rdata_d[`UMP_ST_ALINES] = dec_alines;
        rdata_d[`UMP_ST_PAIRS] = dec_pairs;
        rdata_d[`UMP_ST_QUEUES] = queues_per_phy;
        rdata_d[`UMP_ST_ERR] = err_q;
        rdata_d[`UMP_ST_MAPPED] = mapped_q;
        rdata_d[`UMP_ST_ADDR] = addr_q;
      end
    end
    // Writes land on the edge where waitrequest is low
    if (ack_q && avs_write) begin
      if (widx == `UMP_IDX_CFG2) begin
        mode_d = avs_writedata[`UMP_MODE_MSB:0];
        qsel_d = avs_writedata[`UMP_QSEL_BIT];
      end else if (widx == `UMP_IDX_QCTL) begin
        norm_d = avs_writedata[`UMP_NORM_BIT];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
      rdata_q <= `UMP_WORD_ZERO;
      mode_q <= `UMP_CFG2_RST;
      qsel_q <= 1'b0;
      norm_q <= `UMP_NORM_RST;
    end else begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      mode_q <= mode_d;
      qsel_q <= qsel_d;
      norm_q <= norm_d;
    end
  end

  // Queue allocation per PHY
  always_comb begin
    err_d = (mode_q == `UMP_M_4A2P) && !qsel_q;
    qm_d = QM_FOUR;
    if (mode_q == `UMP_M_4A2P) begin
      qm_d = norm_q ? QM_TWO : QM_PROG;
    end else if (mode_q == `UMP_M_4A1P || mode_q == `UMP_M_2A4P ||
                 mode_q == `UMP_M_3A2P) begin
      if (qsel_q) begin
        qm_d = QM_FOUR;
      end else begin
        qm_d = norm_q ? QM_TWO : QM_PROG;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      qm_q <= QM_FOUR;
      err_q <= 1'b0;
    end else begin
      qm_q <= qm_d;
      err_q <= err_d;
    end
  end

  always_comb begin
    case (qm_q)
      QM_FOUR: queues_per_phy = `UMP_Q_FOUR;
      QM_TWO: queues_per_phy = `UMP_Q_TWO;
      default: queues_per_phy = `UMP_Q_PROG;
    endcase
  end
  assign queue_prog = (qm_q == QM_PROG);
  assign cfg_error = err_q;

  // PHY select: one enable low only for a mapped port
  always_comb begin
    enb_d = `UMP_ENB_IDLE;
    addr_d = addr_q;
    mapped_d = 1'b0;
    clav_d = 1'b0;
    if (sel_valid) begin
      addr_d = dec_addr;
      mapped_d = map_ok;
      if (map_ok) begin
        enb_d[dec_idx] = 1'b0;
        clav_d = phy_clav[dec_idx];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      enb_q <= `UMP_ENB_IDLE;
      addr_q <= `UMP_ADDR_RST;
      mapped_q <= 1'b0;
      clav_q <= 1'b0;
    end else begin
      enb_q <= enb_d;
      addr_q <= addr_d;
      mapped_q <= mapped_d;
      clav_q <= clav_d;
    end
  end

  assign phy_enb_n = enb_q;
  assign phy_addr = addr_q;
  assign sel_mapped = mapped_q;
  assign sel_clav = clav_q;

  a_enb_at_most_one: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    $countones(~phy_enb_n) <= 1)
    else $error("more than one enable asserted");

  a_unmapped_idle: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (sel_valid && !map_ok) |=> (phy_enb_n == `UMP_ENB_IDLE && !sel_clav))
    else $error("unmapped port enabled or polled");

  a_mode16_single: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (mode_q == `UMP_M_4A1P && sel_valid && map_ok)
    |=> (phy_enb_n == 4'hE && phy_addr == $past(sel_port)))
    else $error("16-port mode used wrong pair or address");

  a_mode32_pairs: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (mode_q == `UMP_M_4A2P && sel_valid && map_ok)
    |=> (phy_enb_n[$past(sel_port[4])] == 1'b0 &&
         phy_addr == {1'b0, $past(sel_port[3:0])}))
    else $error("32-port mode mapping wrong");

  a_sparse_even: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (mode_q == `UMP_M_0A4P && sel_valid && sel_port[0])
    |=> (phy_enb_n == `UMP_ENB_IDLE && !sel_mapped))
    else $error("odd port mapped in sparse mode");

  a_qsel_four: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (mode_q == `UMP_M_4A1P && qsel_q) ##1 (mode_q == `UMP_M_4A1P && qsel_q)
    |-> (queues_per_phy == `UMP_Q_FOUR))
    else $error("four queues expected");

  a_qsel_clear: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (mode_q == `UMP_M_4A1P && !qsel_q) |=>
    (queues_per_phy == ($past(norm_q) ? `UMP_Q_TWO : `UMP_Q_PROG)))
    else $error("16-port queue sizing wrong");

  a_q32_sizing: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (mode_q == `UMP_M_4A2P) |=> (queue_prog == !$past(norm_q)))
    else $error("32-port queue sizing wrong");

  a_mode_write: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (avs_write && !avs_waitrequest && widx == `UMP_IDX_CFG2)
    |=> (mode_q == $past(avs_writedata[`UMP_MODE_MSB:0])))
    else $error("mode field not written");

  a_err_blocks: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    cfg_error |-> ##1 (phy_enb_n == `UMP_ENB_IDLE))
    else $error("enable driven in bad 32-port setup");
endmodule // ump_port_map
